//--- hw/pulse_adjust_pkg.sv
// Constants shared by the pulse-adjust stage and the feedback divider
package pulse_adjust_pkg;
    // Feedback divisor width and default divisor N
    localparam int          DIV_WIDTH      = 8;
    localparam logic [7:0]  DIV_N_DEFAULT  = 8'h10;
    // Smallest legal divisor
    localparam logic [7:0]  DIV_N_MIN      = 8'h02;
    // Modulus counter exponent code: 1 gives 2^3, 15 gives 2^17, 0 inhibits
    localparam logic [3:0]  MOD_CODE_OFF   = 4'h0;
    localparam int          MOD_EXP_BASE   = 2;
    localparam int          MOD_WIDTH      = 17;
    // Stage divides its clock by this ratio with no requests
    localparam int          STAGE_RATIO    = 2;
    // Plain stage clocks required between two applied requests
    localparam logic [1:0]  ADJUST_GAP     = 2'h2;
    // Stage clock enable: every clock, every second or every fourth clock (same source as modulus counter)
    localparam logic [1:0]  KCLK_DIV_1     = 2'h0;
    localparam logic [1:0]  KCLK_DIV_2     = 2'h1;
    localparam logic [1:0]  KCLK_DIV_4     = 2'h2;
    // Stage phase states
    typedef enum logic [1:0] {
        PH_LOW   = 2'b00,
        PH_HIGH  = 2'b01,
        PH_HOLD  = 2'b10
    } stage_phase_e;
endpackage : pulse_adjust_pkg

//--- hw/feedback_divider.sv
// Up-counting divide-by-N feedback counter
`timescale 1ns/100ps
module feedback_divider (
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic       advance,
    input  wire logic [7:0] divisor,
    output logic      [7:0] count_q,
    output logic            msb_out_q
);
    logic [7:0] last_value;

    // Guard against a divisor below the smallest legal value
    assign last_value = (divisor < pulse_adjust_pkg::DIV_N_MIN)
                        ? pulse_adjust_pkg::DIV_N_MIN - 8'h01 : divisor - 8'h01;

    // Count one per stage pulse and wrap at N-1
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            count_q <= 8'h00;
        end else if (advance) begin
            if (count_q >= last_value) begin
                count_q <= 8'h00;
            end else begin
                count_q <= count_q + 8'h01;
            end
        end
    end

    // Upper half of the count is high, giving a square-ish wave at stage rate over N
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            msb_out_q <= 1'b0;
        end else begin
            msb_out_q <= (count_q >= {1'b0, last_value[7:1]} + 8'h01);
        end
    end

    a_div_wrap: assert property (@(posedge clock) disable iff (!reset_n)
        advance && count_q >= last_value |=> count_q == 8'h00)
        else $error("divider did not wrap");
    a_div_step: assert property (@(posedge clock) disable iff (!reset_n)
        advance && count_q < last_value |=> count_q == $past(count_q) + 8'h01)
        else $error("divider did not advance");
    a_div_hold: assert property (@(posedge clock) disable iff (!reset_n)
        !advance |=> $stable(count_q))
        else $error("divider moved without pulse");
endmodule : feedback_divider

//--- hw/pulse_adjust_divider.sv
// Pulse-adjust stage, modulus counter and feedback divider of a digital loop
`timescale 1ns/100ps
module pulse_adjust_divider (
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic       count_down,
    input  wire logic       count_enable,
    input  wire logic [3:0] modulus_code,
    input  wire logic [1:0] stage_clock_div,
    input  wire logic [7:0] divisor,
    output logic            stage_out_q,
    output logic            carry_q,
    output logic            borrow_q,
    output logic            loop_out_q
);
    // Internal clock runs as the modulus counter clock; the stage runs on a divided enable
    logic [1:0]               div_cnt_q;
    logic                     stage_en;
    logic [16:0]              mod_cnt_q;
    logic [16:0]              mod_top;
    logic                     carry_pend_q;
    logic                     borrow_pend_q;
    logic                     stage_pulse;
    pulse_adjust_pkg::stage_phase_e phase_q;
    logic                     take_carry;
    logic                     take_borrow;
    logic [1:0]               gap_q;
    logic                     toggle;
    logic [4:0]               mod_shift;

    // Stage clock enable: 1, 2 or 4 modulus clocks per stage clock
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            div_cnt_q <= 2'h0;
        end else begin
            div_cnt_q <= div_cnt_q + 2'h1;
        end
    end
    always_comb begin
        unique case (stage_clock_div)
            pulse_adjust_pkg::KCLK_DIV_1: stage_en = 1'b1;
            pulse_adjust_pkg::KCLK_DIV_2: stage_en = div_cnt_q[0];
            pulse_adjust_pkg::KCLK_DIV_4: stage_en = &div_cnt_q;
            default:                      stage_en = 1'b1;
        endcase
    end

    // Modulus K = 2^(code+2); code 0 inhibits counting
    // Five bits: code 15 plus the base of two must not wrap
    assign mod_shift = 5'(modulus_code) + 5'(pulse_adjust_pkg::MOD_EXP_BASE);
    assign mod_top   = (modulus_code == pulse_adjust_pkg::MOD_CODE_OFF) ? 17'h00000
        : 17'((18'h00001 << mod_shift) - 18'h00001);

    // Up/down modulus counter; overflow gives carry, underflow gives borrow
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            mod_cnt_q <= 17'h00000;
            carry_q   <= 1'b0;
            borrow_q  <= 1'b0;
        end else begin
            carry_q  <= 1'b0;
            borrow_q <= 1'b0;
            if (count_enable && modulus_code != pulse_adjust_pkg::MOD_CODE_OFF) begin
                if (count_down) begin
                    if (mod_cnt_q == 17'h00000) begin
                        mod_cnt_q <= mod_top;
                        borrow_q  <= 1'b1;
                    end else begin
                        mod_cnt_q <= mod_cnt_q - 17'h00001;
                    end
                end else begin
                    if (mod_cnt_q >= mod_top) begin
                        mod_cnt_q <= 17'h00000;
                        carry_q   <= 1'b1;
                    end else begin
                        mod_cnt_q <= mod_cnt_q + 17'h00001;
                    end
                end
            end
        end
    end

    // Requests wait for a stage clock outside the hold step; one of each kind held at most
    assign take_carry  = stage_en && carry_pend_q && !borrow_pend_q
                         && phase_q != pulse_adjust_pkg::PH_HOLD
                         && gap_q == pulse_adjust_pkg::ADJUST_GAP;
    assign take_borrow = stage_en && borrow_pend_q && !carry_pend_q
                         && phase_q != pulse_adjust_pkg::PH_HOLD
                         && gap_q == pulse_adjust_pkg::ADJUST_GAP;

    // Two plain stage clocks between adjustments: without this spacing a fast
    // modulus clock would push the deviation to one half instead of one third
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            gap_q <= pulse_adjust_pkg::ADJUST_GAP;
        end else if (take_carry || take_borrow) begin
            gap_q <= 2'h0;
        end else if (stage_en && gap_q != pulse_adjust_pkg::ADJUST_GAP) begin
            gap_q <= gap_q + 2'h1;
        end
    end
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            carry_pend_q  <= 1'b0;
            borrow_pend_q <= 1'b0;
        end else begin
            // Opposite requests cancel; a new request wins over the clear
            if (stage_en && carry_pend_q && borrow_pend_q) begin
                carry_pend_q  <= carry_q;
                borrow_pend_q <= borrow_q;
            end else begin
                carry_pend_q  <= carry_q  | (carry_pend_q  & ~take_carry);
                borrow_pend_q <= borrow_q | (borrow_pend_q & ~take_borrow);
            end
        end
    end

    // Stage: toggle each enable; borrow skips a toggle, carry toggles twice
    // (the extra half cycle is the PH_HOLD step, which toggles on the very next
    // clock, so a carry needs a stage clock slower than the modulus clock)
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            phase_q     <= pulse_adjust_pkg::PH_LOW;
            stage_out_q <= 1'b0;
        end else if (stage_en || phase_q == pulse_adjust_pkg::PH_HOLD) begin
            unique case (phase_q)
                pulse_adjust_pkg::PH_LOW, pulse_adjust_pkg::PH_HIGH: begin
                    if (take_borrow) begin
                        stage_out_q <= stage_out_q;
                    end else if (take_carry) begin
                        stage_out_q <= ~stage_out_q;
                        phase_q     <= pulse_adjust_pkg::PH_HOLD;
                    end else begin
                        stage_out_q <= ~stage_out_q;
                        phase_q     <= stage_out_q ? pulse_adjust_pkg::PH_LOW
                                                   : pulse_adjust_pkg::PH_HIGH;
                    end
                end
                pulse_adjust_pkg::PH_HOLD: begin
                    stage_out_q <= ~stage_out_q;
                    phase_q     <= stage_out_q ? pulse_adjust_pkg::PH_LOW
                                               : pulse_adjust_pkg::PH_HIGH;
                end
                default: phase_q <= pulse_adjust_pkg::PH_LOW;
            endcase
        end
    end

    // Toggle of the stage on this clock, mirroring the process above
    assign toggle      = phase_q == pulse_adjust_pkg::PH_HOLD || (stage_en && !take_borrow);
    // Divider advances on each rising stage edge, so it runs at the stage clock rate over 2N
    assign stage_pulse = toggle && !stage_out_q;

    feedback_divider u_divider (
        .clock     (clock),
        .reset_n   (reset_n),
        .advance   (stage_pulse),
        .divisor   (divisor),
        .count_q   (),
        .msb_out_q (loop_out_q)
    );

    a_stage_toggle: assert property (@(posedge clock) disable iff (!reset_n)
        stage_en && !carry_pend_q && !borrow_pend_q && phase_q != pulse_adjust_pkg::PH_HOLD
        |=> stage_out_q != $past(stage_out_q))
        else $error("stage did not toggle");
    a_borrow_skip: assert property (@(posedge clock) disable iff (!reset_n)
        take_borrow && phase_q != pulse_adjust_pkg::PH_HOLD |=> $stable(stage_out_q))
        else $error("borrow did not drop a pulse");
    a_carry_hold: assert property (@(posedge clock) disable iff (!reset_n)
        take_carry && phase_q != pulse_adjust_pkg::PH_HOLD
        |=> phase_q == pulse_adjust_pkg::PH_HOLD)
        else $error("carry did not add half cycle");
    a_borrow_under: assert property (@(posedge clock) disable iff (!reset_n)
        count_enable && count_down && mod_cnt_q == 17'h00000
        && modulus_code != pulse_adjust_pkg::MOD_CODE_OFF |=> borrow_q)
        else $error("no borrow on underflow");
    a_carry_over: assert property (@(posedge clock) disable iff (!reset_n)
        count_enable && !count_down && mod_cnt_q >= mod_top
        && modulus_code != pulse_adjust_pkg::MOD_CODE_OFF |=> carry_q)
        else $error("no carry on overflow");
    a_mod_inhibit: assert property (@(posedge clock) disable iff (!reset_n)
        modulus_code == pulse_adjust_pkg::MOD_CODE_OFF |=> !carry_q && !borrow_q)
        else $error("inhibited modulus produced request");
    a_mod_idle: assert property (@(posedge clock) disable iff (!reset_n)
        !count_enable |=> !carry_q && !borrow_q)
        else $error("request without enable");
    a_div4_en: assert property (@(posedge clock) disable iff (!reset_n)
        stage_clock_div == pulse_adjust_pkg::KCLK_DIV_4 && stage_en
        |=> stage_clock_div != pulse_adjust_pkg::KCLK_DIV_4 || !stage_en)
        else $error("divide by four enable too fast");
    a_div2_en: assert property (@(posedge clock) disable iff (!reset_n)
        stage_clock_div == pulse_adjust_pkg::KCLK_DIV_2 && stage_en
        |=> stage_clock_div != pulse_adjust_pkg::KCLK_DIV_2 || !stage_en)
        else $error("divide by two enable too fast");

    // Request spacing, hold step, divider hand-off and opposite request cancel
    a_gap_space: assert property (@(posedge clock) disable iff (!reset_n)
        take_carry || take_borrow |=> !(take_carry || take_borrow) [*2])
        else $error("adjustments too close together");
    a_hold_toggle: assert property (@(posedge clock) disable iff (!reset_n)
        phase_q == pulse_adjust_pkg::PH_HOLD |=> stage_out_q != $past(stage_out_q))
        else $error("hold step did not add a toggle");
    a_loop_step: assert property (@(posedge clock) disable iff (!reset_n)
        stage_pulse |=> stage_out_q)
        else $error("divider advanced without rising stage edge");
    a_borrow_no_adv: assert property (@(posedge clock) disable iff (!reset_n)
        take_borrow |-> !stage_pulse)
        else $error("divider advanced on dropped pulse");
    a_pend_cancel: assert property (@(posedge clock) disable iff (!reset_n)
        stage_en && carry_pend_q && borrow_pend_q
        |=> carry_pend_q == $past(carry_q) && borrow_pend_q == $past(borrow_q))
        else $error("opposite requests did not cancel");
endmodule : pulse_adjust_divider

//--- bench/phase_detect_model.sv
// Edge-triggered phase detector model driving the counter direction input
`timescale 1ns/100ps
module phase_detect_model (
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic ref_in,
    input  wire logic loop_in,
    output logic      count_down_q
);
    logic ref_last_q;
    logic loop_last_q;
    // Loop edge sets, reference edge clears; runs on the modulus counter clock, not the stage clock
    always_ff @(posedge clock) begin
        ref_last_q  <= ref_in;
        loop_last_q <= loop_in;
        if (!reset_n) count_down_q <= 1'b0;
        else if (loop_in && !loop_last_q) count_down_q <= 1'b1;
        else if (ref_in && !ref_last_q) count_down_q <= 1'b0;
    end
endmodule : phase_detect_model

//--- bench/tb.sv
// Self-checking bench for the pulse-adjust stage and feedback divider
`timescale 1ns/100ps
module tb;
    logic       clock           = 1'b0;
    logic       reset_n         = 1'b0;
    logic       tb_down         = 1'b0;
    logic       use_pd          = 1'b0;
    logic       count_enable    = 1'b0;
    logic [3:0] modulus_code    = 4'h0;
    logic [1:0] stage_clock_div = 2'h0;
    logic [7:0] divisor         = 8'h10;
    logic       ref_q           = 1'b0;
    logic [7:0] ref_cnt_q       = 8'h00;
    logic       pd_down;
    logic       stage_out_q;
    logic       carry_q;
    logic       borrow_q;
    logic       loop_out_q;
    wire  logic count_down = use_pd ? pd_down : tb_down;
    int         error_cnt   = 0;
    int         check_count = 0;
    int         tog, cy, bo, lr, lfirst, llast, seed_val;

    always #20 clock = ~clock;
    // Reference of 34 clocks, a little slower than the 32-clock centre
    always @(posedge clock) begin
        ref_cnt_q <= (ref_cnt_q == 8'h10) ? 8'h00 : ref_cnt_q + 8'h01;
        if (ref_cnt_q == 8'h10) ref_q <= ~ref_q;
    end

    pulse_adjust_divider u_dut (.clock(clock), .reset_n(reset_n), .count_down(count_down),
        .count_enable(count_enable), .modulus_code(modulus_code),
        .stage_clock_div(stage_clock_div), .divisor(divisor), .stage_out_q(stage_out_q),
        .carry_q(carry_q), .borrow_q(borrow_q), .loop_out_q(loop_out_q));
    phase_detect_model u_pd (.clock(clock), .reset_n(reset_n), .ref_in(ref_q),
        .loop_in(loop_out_q), .count_down_q(pd_down));

    function automatic int rate(input int sd);
        return (sd == 1) ? 2 : ((sd == 2) ? 4 : 1);
    endfunction : rate
    // Toggles in w clocks; the deviation is capped at a third of nominal
    function automatic int exp_tog(input int sd, input int dn, input int w, input int k);
        int nom;
        int dev;
        nom = w / rate(sd);
        dev = (w / k < nom / 3) ? w / k : nom / 3;
        return dn ? nom - dev : nom + dev;
    endfunction : exp_tog

    task automatic step();
        @(posedge clock);
        #1;
    endtask : step
    task automatic set(input int sd, input int code, input int en, input int dn);
        stage_clock_div = sd[1:0];
        modulus_code    = code[3:0];
        count_enable    = en[0];
        tb_down         = dn[0];
    endtask : set
    // Counts toggles, pulses and loop rising edges over w clocks
    task automatic run(input int w);
        logic s;
        logic l;
        tog = 0; cy = 0; bo = 0; lr = 0; lfirst = -1; llast = -1;
        for (int i = 0; i < w; i++) begin
            s = stage_out_q;
            l = loop_out_q;
            step();
            if (stage_out_q !== s) tog++;
            if (carry_q === 1'b1) cy++;
            if (borrow_q === 1'b1) bo++;
            if (loop_out_q === 1'b1 && l === 1'b0) begin
                if (lfirst < 0) lfirst = i;
                llast = i;
                lr++;
            end
        end
    endtask : run
    task automatic chk(input string name, input int exp, input int got, input int tol);
        check_count++;
        if (got > exp + tol || got < exp - tol || stage_out_q === 1'bx) begin
            error_cnt++;
            $display("unexpected %s: expected %0d seen %0d", name, exp, got);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop

    initial begin
        int n;
        int sd;
        int ex;
        seed_val = $urandom(65);
        repeat (20) step();
        reset_n = 1'b1;
        // Plain division in every enable mode, requests inhibited by code 0
        for (int d = 0; d < 4; d++) begin
            set(d, 0, 1, d % 2);
            run(16);
            run(96);
            chk("stage toggles", 96 / rate(d), tog, 1);
            chk("inhibited requests", 0, cy + bo, 0);
        end
        // Overflow and underflow spacing for several moduli
        for (int c = 1; c < 5; c++) for (int dn = 0; dn < 2; dn++) begin
            set(0, c, 1, dn);
            run(16);
            run(8 << (c + 2));
            chk("borrows", dn ? 8 : 0, bo, 1);
            chk("carries", dn ? 0 : 8, cy, 1);
        end
        // Frequency limits with K=8 and the three clock ratios
        for (int s = 0; s < 3; s++) for (int dn = 0; dn < 2; dn++) if (s != 0 || dn) begin
            set(s, 1, 1, dn);
            run(64);
            run(192);
            ex = exp_tog(s, dn, 192, 8);
            chk("adjusted toggles", ex, tog, 2);
        end
        // Divider period at the extreme and random divisors
        for (int i = 0; i < 6; i++) begin
            n  = (i == 0) ? 2 : ((i == 1) ? 255 : 3 + $urandom % 60);
            sd = $urandom % 3;
            set(sd, 0, 0, 0);
            divisor = n[7:0];
            run(4 * n * rate(sd));
            run(8 * n * rate(sd) + 2);
            ex = (lr - 1) * 2 * n * rate(sd);
            chk("loop period", ex, llast - lfirst, 0);
        end
        // Closed loop pulls onto the slower reference
        divisor = 8'h10;
        set(0, 1, 1, 0);
        use_pd = 1'b1;
        run(3000);
        run(350);
        chk("locked period", (lr - 1) * 34, llast - lfirst, 8);
        report_and_stop();
    end
endmodule : tb
